// ==== logic/lgv_consts.svh ====
// Offsets, field positions and reset values of the low-side gating block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef LGV_CONSTS_SVH
`define LGV_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LGV_OFS_CTRL       8'h00
`define LGV_OFS_SLEW       8'h04
`define LGV_OFS_LS_THR     8'h08
`define LGV_OFS_HS_DS_THR  8'h0c
`define LGV_OFS_HS_FW_THR  8'h10
`define LGV_OFS_LIVE       8'h14
`define LGV_OFS_EVT_STAT   8'h18
`define LGV_OFS_EVT_CLR    8'h1c
`define LGV_OFS_EVT_EN     8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LGV_CTRL_SHUT_BIT  0
`define LGV_CTRL_OVR_BIT   1
`define LGV_LIVE_REF_LSB   15
`define LGV_LIVE_GATE_LSB  18
`define LGV_OVR_CHAN       6

// ----------------------------------------------------------------------
// Reset values and threshold codes
// ----------------------------------------------------------------------
`define LGV_RST_SLEW       12'h000
`define LGV_RST_THR24      24'h000000
`define LGV_RST_THR12      12'h000
`define LGV_THR_ZERO       4'h0
`define LGV_THR_MAX_LOW    4'h7
`define LGV_THR_MIN_FINE   4'h9
`define LGV_THR_MAX_FINE   4'hc

`endif

// ==== logic/lgv_pkg.sv ====
// Types shared by the low-side gating block and its bench.
// Assumes lgv_consts.svh holds every number.
package lgv_pkg;

  // Synchronised or raw comparator results, one bit per comparator
  typedef struct packed {
    logic [2:0] hs_fw;
    logic [2:0] hs_batt;
    logic [2:0] hs_boost;
    logic [5:0] ls_drain;
  } lgv_cmp_s;

  // Drain reference select from the microcore
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;   // 0,1,2 for high-side 2,4,6
    logic       boost;
  } lgv_fbk_s;

  // Supply and clock conditions
  typedef struct packed {
    logic drive_permit;
    logic predriver_supply_low;
    logic logic_supply_low;
    logic pll_locked;
    logic reset_n_pin;
  } lgv_cond_s;

  // Whole state of the block
  typedef struct packed {
    lgv_cmp_s    cmp_meta;
    lgv_cmp_s    cmp_sync;
    lgv_cmp_s    cmp_prev;
    logic        shut_en;
    logic        permit_override_ch_six;
    logic [11:0] slew;
    logic [23:0] ls_thr;
    logic [11:0] high_drain_threshold;
    logic [11:0] high_freewheel_threshold;
    logic [2:0]  ref_boost;
    logic [14:0] evt;
    logic [14:0] evt_en;
    logic        irq;
    logic [5:0]  gate;
    logic [23:0] ls_code;
    logic [11:0] hs_ds_code;
    logic [11:0] hs_fw_code;
    logic        ack;
    logic [31:0] rdat;
  } lgv_state_s;

endpackage

// ==== logic/lgv_lowside_gate.sv ====
// Low-side gate gating, edge strength, threshold coding and comparator
// monitoring, with a classic Wishbone register slave.
// Assumes inputs synchronous to clk_sys except the comparator results.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "lgv_consts.svh"

// Behaviour
// - Gate command forced low while drive permit is low, unless overridden.
// - Only channel six has a permit override; other gating still applies.
// - Pre-driver supply low forces every gate command low.
// - Logic supply low forces every gate command low.
// - Lost PLL lock forces gates low only when shutdown enable set; default off.
// - Command high only with channel request high and all gating permitting.
// - Gate output follows the gate command.
// - Reset pin low holds every gate output off.
// - Each driver has its own 2-bit edge strength, 00 fastest.
// - Low-side drain threshold uses the documented 4-bit code table.
// - High-side drain and source thresholds set by registers, same code table.
// - Microcore select chooses battery or boost drain reference on channels 2,4,6.
// - High-side 2,4,6 each give boost, battery and free-wheel comparator results.
// - High drain comparator: source against supply minus threshold.
// - Free-wheel comparator: source against ground plus threshold.
// - Low-side monitor compares drain against ground, sense resistor included.
module lgv_lowside_gate (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // Classic Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic                    wb_ack_o,
  output logic [31:0]             wb_dat_o,
  // Interrupt
  output logic                    irq,
  // Channel logic and conditions
  input  wire logic [5:0]         chan_request,
  input  wire lgv_pkg::lgv_cond_s cond,
  input  wire lgv_pkg::lgv_fbk_s  fbk_sel,
  // Analog comparators, asynchronous
  input  wire lgv_pkg::lgv_cmp_s  cmp_raw,
  // Pre-driver and comparator settings
  output logic [5:0]              ls_gate,
  output logic [11:0]             ls_slew,
  output logic [23:0]             ls_vds_code,
  output logic [11:0]             hs_ds_code,
  output logic [11:0]             hs_fw_code,
  output logic [2:0]              hs_ref_boost
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Unlisted codes fold to zero volts so a stray write never arms a
  // comparator at an undefined level
  function automatic logic [3:0] thr_fix(input logic [3:0] code);
    if (code <= `LGV_THR_MAX_LOW) begin
      thr_fix = code;
    end else if (code >= `LGV_THR_MIN_FINE && code <= `LGV_THR_MAX_FINE) begin
      thr_fix = code;
    end else begin
      thr_fix = `LGV_THR_ZERO;
    end
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  lgv_pkg::lgv_state_s state_reg;
  lgv_pkg::lgv_state_s state_next;

  logic                wr_hit;
  logic                rd_hit;
  logic [31:0]         merged;
  logic [31:0]         ctrl_word;
  logic [14:0]         rise;
  logic [14:0]         clr_mask;
  logic                permit;
  logic                clock_ok;
  logic                supply_ok;

  // Bus decode: answer one cycle after the request, drop after one
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !state_reg.ack;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !state_reg.ack;

  // Control word as software sees it
  assign ctrl_word = {30'h00000000, state_reg.permit_override_ch_six, state_reg.shut_en};

  // Merge source follows the register addressed
  always_comb begin
    case (wb_adr_i)
      `LGV_OFS_CTRL:      merged = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
      `LGV_OFS_SLEW:      merged = lane_merge({20'h00000, state_reg.slew}, wb_dat_i, wb_sel_i);
      `LGV_OFS_LS_THR:    merged = lane_merge({8'h00, state_reg.ls_thr}, wb_dat_i, wb_sel_i);
      `LGV_OFS_HS_DS_THR: merged = lane_merge({20'h00000, state_reg.high_drain_threshold},
                                              wb_dat_i, wb_sel_i);
      `LGV_OFS_HS_FW_THR: merged = lane_merge({20'h00000, state_reg.high_freewheel_threshold},
                                              wb_dat_i, wb_sel_i);
      `LGV_OFS_EVT_CLR:   merged = lane_merge(32'h00000000, wb_dat_i, wb_sel_i);
      `LGV_OFS_EVT_EN:    merged = lane_merge({17'h00000, state_reg.evt_en}, wb_dat_i, wb_sel_i);
      default:            merged = 32'h00000000;
    endcase
  end

  // Events are rising edges of the synchronised comparators
  assign rise     = state_reg.cmp_sync & ~state_reg.cmp_prev;
  assign clr_mask = (wr_hit && wb_adr_i == `LGV_OFS_EVT_CLR) ? merged[14:0] : 15'h0000;

  // Gating terms shared by all six channels
  assign permit    = cond.drive_permit;
  assign clock_ok  = cond.pll_locked || !state_reg.shut_en;
  assign supply_ok = !cond.predriver_supply_low
                     && !cond.logic_supply_low;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // Comparator synchronisers; stage one feeds nothing but stage two
    state_next.cmp_meta = cmp_raw;
    state_next.cmp_sync = state_reg.cmp_meta;
    state_next.cmp_prev = state_reg.cmp_sync;

    // Register writes
    if (wr_hit) begin
      case (wb_adr_i)
        `LGV_OFS_CTRL: begin
          state_next.shut_en                = merged[`LGV_CTRL_SHUT_BIT];
          state_next.permit_override_ch_six = merged[`LGV_CTRL_OVR_BIT];
        end
        `LGV_OFS_SLEW: begin
          state_next.slew = merged[11:0];
        end
        `LGV_OFS_LS_THR: begin
          state_next.ls_thr = merged[23:0];
        end
        `LGV_OFS_HS_DS_THR: begin
          state_next.high_drain_threshold = merged[11:0];
        end
        `LGV_OFS_HS_FW_THR: begin
          state_next.high_freewheel_threshold = merged[11:0];
        end
        `LGV_OFS_EVT_EN: begin
          state_next.evt_en = merged[14:0];
        end
        default: begin
          state_next.shut_en = state_reg.shut_en;
        end
      endcase
    end

    // Sticky events: a new edge wins over a clear in the same cycle
    state_next.evt = (state_reg.evt & ~clr_mask) | rise;
    state_next.irq = |(state_next.evt & state_reg.evt_en);

    // Drain reference select from the microcore instruction
    if (fbk_sel.valid && fbk_sel.chan <= 2'd2) begin
      state_next.ref_boost[fbk_sel.chan] = fbk_sel.boost;
    end

    // Threshold codes to the comparators, cleaned of unlisted values
    for (int i = 0; i < 6; i++) begin
      state_next.ls_code[i*4 +: 4] = thr_fix(state_reg.ls_thr[i*4 +: 4]);
    end
    for (int i = 0; i < 3; i++) begin
      state_next.hs_ds_code[i*4 +: 4] =
        thr_fix(state_reg.high_drain_threshold[i*4 +: 4]);
      state_next.hs_fw_code[i*4 +: 4] =
        thr_fix(state_reg.high_freewheel_threshold[i*4 +: 4]);
    end

    // Gate commands; the register is the gate pin level
    for (int i = 0; i < 6; i++) begin
      state_next.gate[i] = chan_request[i]
                           && (permit || (i == `LGV_OVR_CHAN - 1
                                          && state_reg.permit_override_ch_six))
                           && supply_ok && clock_ok
                           && cond.reset_n_pin;
    end

    // Bus answer and read data
    state_next.ack  = wb_cyc_i && wb_stb_i && !state_reg.ack;
    state_next.rdat = 32'h00000000;
    if (rd_hit) begin
      case (wb_adr_i)
        `LGV_OFS_CTRL:      state_next.rdat = ctrl_word;
        `LGV_OFS_SLEW:      state_next.rdat = {20'h00000, state_reg.slew};
        `LGV_OFS_LS_THR:    state_next.rdat = {8'h00, state_reg.ls_thr};
        `LGV_OFS_HS_DS_THR: state_next.rdat = {20'h00000, state_reg.high_drain_threshold};
        `LGV_OFS_HS_FW_THR: state_next.rdat = {20'h00000, state_reg.high_freewheel_threshold};
        `LGV_OFS_LIVE:      state_next.rdat = {8'h00, state_reg.gate, state_reg.ref_boost,
                                               state_reg.cmp_sync};
        `LGV_OFS_EVT_STAT:  state_next.rdat = {17'h00000, state_reg.evt};
        `LGV_OFS_EVT_EN:    state_next.rdat = {17'h00000, state_reg.evt_en};
        default:            state_next.rdat = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------

  // Synchronous reset: gates off, clock-loss shutdown disabled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg                          <= '0;
      state_reg.shut_en                  <= 1'b0;
      state_reg.slew                     <= `LGV_RST_SLEW;
      state_reg.ls_thr                   <= `LGV_RST_THR24;
      state_reg.high_drain_threshold     <= `LGV_RST_THR12;
      state_reg.high_freewheel_threshold <= `LGV_RST_THR12;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign wb_ack_o     = state_reg.ack;
  assign wb_dat_o     = state_reg.rdat;
  assign irq          = state_reg.irq;
  assign ls_gate      = state_reg.gate;
  assign ls_slew      = state_reg.slew;
  assign ls_vds_code  = state_reg.ls_code;
  assign hs_ds_code   = state_reg.hs_ds_code;
  assign hs_fw_code   = state_reg.hs_fw_code;
  assign hs_ref_boost = state_reg.ref_boost;

endmodule // lgv_lowside_gate

// ==== testbench/lgv_lowside_gate_chk.sv ====
// Port-level checker for the low-side gating block.
// Assumes it is bound onto lgv_lowside_gate by the bench top.
`timescale 1ns/1ps
module lgv_lowside_gate_chk (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               srst,
  // Bus handshake
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  // Gating and monitor settings
  input wire logic [5:0]         chan_request,
  input wire lgv_pkg::lgv_cond_s cond,
  input wire lgv_pkg::lgv_fbk_s  fbk_sel,
  input wire logic [5:0]         ls_gate,
  input wire logic [23:0]        ls_vds_code,
  input wire logic [2:0]         hs_ref_boost
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ------------
  // Gate command
  // ------------
  a_req_gate: assert property (1'b1 |=> (ls_gate & ~$past(chan_request)) == 6'h00)
    else $error("gate on without request");
  a_permit_off: assert property (!cond.drive_permit |=> ls_gate[4:0] == 5'h00)
    else $error("gate on without permit");
  a_pre_low: assert property (cond.predriver_supply_low |=> ls_gate == 6'h00)
    else $error("gate on in predriver undervoltage");
  a_logic_low: assert property (cond.logic_supply_low |=> ls_gate == 6'h00)
    else $error("gate on in logic undervoltage");
  a_pin_reset: assert property (!cond.reset_n_pin |=> ls_gate == 6'h00)
    else $error("gate on while reset pin low");
  a_gate_cause: assert property (ls_gate[0] |-> $past(cond.drive_permit) && $past(chan_request[0]))
    else $error("gate output without its cause");
  // ---------------------
  // Bus and monitor setup
  // ---------------------
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ref_select: assert property (fbk_sel.valid && fbk_sel.chan == 2'd2
    |=> hs_ref_boost[2] == $past(fbk_sel.boost))
    else $error("reference select not taken");
  a_code_clean: assert property (!(ls_vds_code[3:0] inside {4'h8, 4'hd, 4'he, 4'hf}))
    else $error("unlisted threshold code passed on");
  // Main scenarios reached
  c_override: cover property (!cond.drive_permit ##1 ls_gate[5]);
  c_ack: cover property (wb_ack_o);
  c_boost: cover property ($rose(hs_ref_boost[2]));
endmodule // lgv_lowside_gate_chk

// ==== testbench/lgv_fet_model.sv ====
// Model of the external FETs and the analog monitor comparators.
// Assumes the bench sets high-side comparator levels directly.
`timescale 1ns/1ps
module lgv_fet_model (
  // Gate pins from the block
  input  wire logic [5:0]   ls_gate,
  // High-side comparator levels from the bench
  input  wire logic [8:0]   hs_level,
  // Comparator results to the block
  output lgv_pkg::lgv_cmp_s cmp_raw
);
  // Drain sits near ground while the FET conducts, so a ground
  // referenced compare trips only with the gate off
  assign cmp_raw.ls_drain = ~ls_gate;
  // Supply-minus-threshold trips, boost and battery referenced
  assign cmp_raw.hs_boost = hs_level[2:0];
  assign cmp_raw.hs_batt  = hs_level[5:3];
  // Ground-plus-threshold trip across the free-wheel element
  assign cmp_raw.hs_fw    = hs_level[8:6];
endmodule // lgv_fet_model

// ==== testbench/lgv_lowside_gate_bench.sv ====
// Self-checking bench for the low-side gating block.
// Assumes the checker and the FET model are compiled first.
`timescale 1ns/1ps
bind lgv_lowside_gate lgv_lowside_gate_chk u_chk (.clk_sys, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .chan_request, .cond, .fbk_sel, .ls_gate, .ls_vds_code, .hs_ref_boost);
module lgv_lowside_gate_bench;
  // Design signals
  logic               clk_sys = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0, wb_ack_o, irq;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [3:0]         wb_sel_i = 4'hf;
  logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [5:0]         chan_request = 6'h00, ls_gate;
  logic [8:0]         hs_level = 9'h000;
  logic [11:0]        ls_slew, hs_ds_code, hs_fw_code;
  logic [23:0]        ls_vds_code;
  logic [2:0]         hs_ref_boost;
  lgv_pkg::lgv_cond_s cond = 5'h13;
  lgv_pkg::lgv_fbk_s  fbk_sel = 4'h0;
  lgv_pkg::lgv_cmp_s  cmp_raw;
  int                 error_cnt = 0, samples_checked = 0;
  // Gating rows: request, conditions, expected gates
  logic [16:0] rows [7] = '{{6'h3f, 5'h13, 6'h3f}, {6'h3f, 5'h03, 6'h00},
    {6'h3f, 5'h1b, 6'h00}, {6'h3f, 5'h17, 6'h00}, {6'h3f, 5'h11, 6'h3f},
    {6'h3f, 5'h12, 6'h00}, {6'h15, 5'h13, 6'h15}};

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  lgv_lowside_gate u_dut (.clk_sys, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .irq, .chan_request, .cond, .fbk_sel,
    .cmp_raw, .ls_gate, .ls_slew, .ls_vds_code, .hs_ds_code, .hs_fw_code, .hs_ref_boost);
  lgv_fet_model u_fet (.ls_gate, .hs_level, .cmp_raw);

  // ------------
  // Shared tasks
  // ------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Classic single cycle; read data taken at the falling edge that sees ack high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    // Look at ack mid-cycle so the registered pulse is read where it stands
    do begin
      @(negedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
    rd = wb_dat_o;
    // Release only after the rising edge that samples ack high
    @(posedge clk_sys);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Gate output is one edge behind its inputs
  task automatic gate(input logic [5:0] req, input logic [4:0] c, input logic [5:0] exp);
    @(posedge clk_sys);
    chan_request <= req;
    cond <= c;
    repeat (2) @(posedge clk_sys);
    #1 check({26'h0, ls_gate}, {26'h0, exp});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // Hang guard; a timeout counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  // ------------
  // Main sequence
  // ------------
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    foreach (rows[i]) gate(rows[i][16:11], rows[i][10:6], rows[i][5:0]);
    wb(1'b1, 8'h00, 32'h2);
    gate(6'h3f, 5'h03, 6'h20);
    gate(6'h3f, 5'h0b, 6'h00);
    wb(1'b1, 8'h00, 32'h1);
    gate(6'h3f, 5'h11, 6'h00);
    // Slew and threshold codes, with unlisted codes mixed in
    wb(1'b1, 8'h04, 32'h6e4);
    wb(1'b1, 8'h08, 32'hfd8c90);
    wb(1'b1, 8'h0c, 32'h7f1);
    wb(1'b1, 8'h10, 32'he63);
    settle();
    check({20'h0, ls_slew}, 32'h6e4);
    check({8'h0, ls_vds_code}, 32'hc90);
    check({20'h0, hs_ds_code}, 32'h701);
    check({20'h0, hs_fw_code}, 32'h063);
    // Boost reference on the third monitored channel, one-cycle strobe
    @(posedge clk_sys);
    fbk_sel <= 4'hd;
    @(posedge clk_sys);
    fbk_sel <= 4'h0;
    settle();
    check({29'h0, hs_ref_boost}, 32'h4);
    // Events: masked first, then enabled, then cleared
    gate(6'h00, 5'h13, 6'h00);
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b1, 8'h1c, 32'h7fff);
    @(posedge clk_sys);
    hs_level <= 9'h001;
    settle();
    wb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h40);
    check({31'h0, irq}, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h2007f);
    wb(1'b1, 8'h20, 32'h40);
    settle();
    check({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h1c, 32'h40);
    settle();
    check({31'h0, irq}, 32'h0);
    // Mid-run reset returns control to its defaults
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    conclude();
  end
endmodule // lgv_lowside_gate_bench
